// >>> ess_sequencer.sv
// EEPROM store sequencer with its AXI4-Lite register file.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module ess_sequencer
	import ess_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address channel.
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [15:0] awaddr,
	input  wire logic [2:0]  awprot,
	// AXI4-Lite write data channel.
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// AXI4-Lite write response channel.
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// AXI4-Lite read address channel.
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [15:0] araddr,
	input  wire logic [2:0]  arprot,
	// AXI4-Lite read data channel.
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Register map read port.
	output logic             map_req,
	output logic [15:0]      map_addr,
	input  wire logic        map_ack,
	input  wire logic [7:0]  map_rdata,
	// EEPROM byte write port.
	output logic             ee_valid,
	input  wire logic        ee_ready,
	output ess_ee_wr_t       ee_wr
);

	logic [7:0]  seq_instr [SEQ_ENTRIES];
	logic [15:0] seq_start [SEQ_ENTRIES];
	logic [15:0] base_ptr;
	logic        start_pulse;
	logic        done;

	ess_state_t  state;
	logic [1:0]  entry;
	logic [15:0] ptr;
	logic [8:0]  count;
	logic [15:0] cur_start;

	ess_bus_wr_t wr_q;
	logic        aw_held;
	logic        w_held;
	logic        do_write;
	logic        wr_hit;
	logic [15:0] first_ptr;
	logic [1:0]  next_entry;
	logic        last_byte;

	// Writes wait until both address and data are held, so that the
	// two channels may arrive in either order.
	assign awready  = !aw_held;
	assign wready   = !w_held;
	assign do_write = aw_held && w_held && !bvalid;
	assign arready  = !rvalid;

	// Entries hold the data step of one group: its count and start.
	function automatic logic [8:0] step_count(input logic [7:0] instr);
		step_count = {1'b0, instr} + 9'h001;
	endfunction

	function automatic logic [31:0] rd_value(input logic [11:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int i = 0; i < SEQ_ENTRIES; i++) begin
			if (idx == IDX_INSTR[i]) begin
				v = {24'h00_0000, seq_instr[i]};
			end
			if (idx == IDX_START[i]) begin
				v = {16'h0000, seq_start[i]};
			end
		end
		if (idx == IDX_BASE) begin
			v = {16'h0000, base_ptr};
		end
		if (idx == IDX_STATUS) begin
			v[STAT_BUSY_BIT] = (state != ST_IDLE);
			v[STAT_DONE_BIT] = done;
		end
		if (idx == IDX_POINTER) begin
			v = {16'h0000, ptr};
		end
		rd_value = v;
	endfunction

	function automatic logic is_mapped(input logic [11:0] idx);
		logic m;
		m = (idx == IDX_CTRL) || (idx == IDX_BASE) ||
			(idx == IDX_STATUS) || (idx == IDX_POINTER);
		for (int i = 0; i < SEQ_ENTRIES; i++) begin
			if (idx == IDX_INSTR[i] || idx == IDX_START[i]) begin
				m = 1'b1;
			end
		end
		is_mapped = m;
	endfunction

	assign wr_hit = wr_q.mapped_hi && is_mapped(wr_q.idx);

	// Write address and data capture.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_q    <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_held        <= 1'b1;
				wr_q.idx       <= awaddr[13:2];
				wr_q.mapped_hi <= (awaddr[15:14] == 2'h0);
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held    <= 1'b1;
				wr_q.data <= wdata;
				wr_q.strb <= wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer with a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Read channel.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			if (araddr[15:14] == 2'h0 && is_mapped(araddr[13:2])) begin
				rdata <= rd_value(araddr[13:2]);
				rresp <= RESP_OKAY;
			end else begin
				rdata <= 32'h0000_0000;
				rresp <= RESP_SLVERR;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// Sequence registers and the EEPROM base pointer. Software may
	// rewrite them during a run; an entry is sampled when it starts.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < SEQ_ENTRIES; i++) begin
				seq_instr[i] <= INSTR_RESET[i];
				seq_start[i] <= START_RESET[i];
			end
			base_ptr <= BASE_RESET;
		end else if (do_write && wr_q.mapped_hi) begin
			for (int i = 0; i < SEQ_ENTRIES; i++) begin
				if (wr_q.idx == IDX_INSTR[i] && wr_q.strb[0]) begin
					seq_instr[i] <= wr_q.data[7:0];
				end
				if (wr_q.idx == IDX_START[i]) begin
					if (wr_q.strb[0]) begin
						seq_start[i][7:0] <= wr_q.data[7:0];
					end
					if (wr_q.strb[1]) begin
						seq_start[i][15:8] <= wr_q.data[15:8];
					end
				end
			end
			if (wr_q.idx == IDX_BASE) begin
				if (wr_q.strb[0]) begin
					base_ptr[7:0] <= wr_q.data[7:0];
				end
				if (wr_q.strb[1]) begin
					base_ptr[15:8] <= wr_q.data[15:8];
				end
			end
		end
	end

	// Start command; a start while a run is under way is ignored.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_pulse <= 1'b0;
		end else begin
			start_pulse <= do_write && wr_q.mapped_hi &&
				wr_q.idx == IDX_CTRL && wr_q.strb[0] &&
				wr_q.data[CTRL_START_BIT] && state == ST_IDLE;
		end
	end

	// Done is sticky until the next start. Completion cannot coincide
	// with an accepted start, since starts are only taken when idle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done <= 1'b0;
		end else if (last_byte && entry == LAST_ENTRY) begin
			done <= 1'b1;
		end else if (start_pulse) begin
			done <= 1'b0;
		end
	end

	// The first entry lands just after the preceding general step.
	assign first_ptr  = base_ptr + PRIOR_HEADER_BYTES +
		PRIOR_DATA_ADVANCE;
	assign next_entry = entry + 2'h1;
	assign last_byte  = (state == ST_DATA_WR) && ee_ready &&
		(count == 9'h001);
	assign ee_valid   = (state == ST_INSTR) || (state == ST_ADDR_HI) ||
		(state == ST_ADDR_LO) || (state == ST_DATA_WR);
	assign map_req    = (state == ST_MAP_RD);

	// Sequencer: instruction byte, address bytes, then the data bytes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= ST_IDLE;
			entry     <= 2'h0;
			count     <= 9'h000;
			cur_start <= 16'h0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_pulse) begin
						entry     <= 2'h0;
						count     <= step_count(seq_instr[0]);
						cur_start <= seq_start[0];
						state     <= ST_INSTR;
					end
				end
				ST_INSTR: begin
					if (ee_ready) begin
						state <= ST_ADDR_HI;
					end
				end
				ST_ADDR_HI: begin
					if (ee_ready) begin
						state <= ST_ADDR_LO;
					end
				end
				ST_ADDR_LO: begin
					if (ee_ready) begin
						state <= ST_MAP_RD;
					end
				end
				ST_MAP_RD: begin
					if (map_ack) begin
						state <= ST_DATA_WR;
					end
				end
				ST_DATA_WR: begin
					if (ee_ready) begin
						count <= count - 9'h001;
						if (count != 9'h001) begin
							state <= ST_MAP_RD;
						end else if (entry == LAST_ENTRY) begin
							state <= ST_IDLE;
						end else begin
							// Next entry only after this one is complete.
							entry     <= next_entry;
							count     <= step_count(seq_instr[next_entry]);
							cur_start <= seq_start[next_entry];
							state     <= ST_INSTR;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// The pointer steps once for every byte that the EEPROM takes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ptr <= 16'h0000;
		end else if (start_pulse && state == ST_IDLE) begin
			ptr <= first_ptr;
		end else if (ee_valid && ee_ready) begin
			ptr <= ptr + 16'h0001;
		end
	end

	// Register map reads walk up from the start address of the entry.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			map_addr <= 16'h0000;
		end else if (state == ST_ADDR_LO && ee_ready) begin
			map_addr <= cur_start;
		end else if (state == ST_DATA_WR && ee_ready) begin
			map_addr <= map_addr + 16'h0001;
		end
	end

	// Header bytes are loaded as the byte before is taken (the first one at
	// the start) and data bytes as the map read answers, so ee_wr never
	// changes while a byte is offered and stalled.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ee_wr <= '0;
		end else if (start_pulse && state == ST_IDLE) begin
			ee_wr.addr <= first_ptr;
			ee_wr.data <= seq_instr[0];
		end else if (state == ST_INSTR && ee_ready) begin
			ee_wr.addr <= ptr + 16'h0001;
			ee_wr.data <= cur_start[15:8];
		end else if (state == ST_ADDR_HI && ee_ready) begin
			ee_wr.addr <= ptr + 16'h0001;
			ee_wr.data <= cur_start[7:0];
		end else if (state == ST_MAP_RD && map_ack) begin
			ee_wr.addr <= ptr;
			ee_wr.data <= map_rdata;
		end else if (last_byte && entry != LAST_ENTRY) begin
			ee_wr.addr <= ptr + 16'h0001;
			ee_wr.data <= seq_instr[next_entry];
		end
	end

endmodule

`default_nettype wire

// >>> ess_pkg.sv
// Constants, types and register map of the EEPROM store sequencer.
`default_nettype none
package ess_pkg;

	// Sequence entries handled by this block, walked in ascending order.
	localparam int             SEQ_ENTRIES  = 3;
	localparam logic [1:0]     LAST_ENTRY   = 2'h2;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [11:0]    IDX_INSTR [SEQ_ENTRIES] =
		'{12'he2b, 12'he2e, 12'he31};
	localparam logic [11:0]    IDX_START [SEQ_ENTRIES] =
		'{12'he2c, 12'he2f, 12'he32};
	localparam logic [11:0]    IDX_CTRL     = 12'hf00;
	localparam logic [11:0]    IDX_BASE     = 12'hf01;
	localparam logic [11:0]    IDX_STATUS   = 12'hf02;
	localparam logic [11:0]    IDX_POINTER  = 12'hf03;

	// Values after reset of the sequence registers.
	localparam logic [7:0]     INSTR_RESET [SEQ_ENTRIES] =
		'{8'h0e, 8'h33, 8'h1e};
	localparam logic [15:0]    START_RESET [SEQ_ENTRIES] =
		'{16'h0430, 16'h0440, 16'h0500};
	localparam logic [15:0]    BASE_RESET   = 16'h0000;

	// Field positions in the control and status words.
	localparam int             CTRL_START_BIT  = 0;
	localparam int             STAT_BUSY_BIT   = 0;
	localparam int             STAT_DONE_BIT   = 1;

	// Footprint of the preceding digital_loop_zero general step in the
	// EEPROM: instruction and address bytes, then 31 data bytes plus
	// one checksum byte.
	localparam logic [15:0]    PRIOR_HEADER_BYTES = 16'h0003;
	localparam logic [15:0]    PRIOR_DATA_ADVANCE = 16'h0020;

	// Bus answers.
	localparam logic [1:0]     RESP_OKAY    = 2'h0;
	localparam logic [1:0]     RESP_SLVERR  = 2'h2;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_INSTR   = 6'h02,
		ST_ADDR_HI = 6'h04,
		ST_ADDR_LO = 6'h08,
		ST_MAP_RD  = 6'h10,
		ST_DATA_WR = 6'h20
	} ess_state_t;

	// One byte written into the EEPROM at one pointer value.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} ess_ee_wr_t;

	// A bus write held until both address and data have arrived.
	typedef struct packed {
		logic [11:0] idx;
		logic        mapped_hi;
		logic [31:0] data;
		logic [3:0]  strb;
	} ess_bus_wr_t;

endpackage
`default_nettype wire

// >>> ess_sequencer_assertions.sv
// Port assertions for the EEPROM store sequencer.
`timescale 1ns/1ns
`default_nettype none
module ess_sequencer_chk
	import ess_pkg::*;
(
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus.
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	// Far side.
	input wire logic        map_req,
	input wire logic [15:0] map_addr,
	input wire logic        map_ack,
	input wire logic [7:0]  map_rdata,
	input wire logic        ee_valid,
	input wire logic        ee_ready,
	input wire ess_ee_wr_t  ee_wr
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [15:0] last_addr;
	logic [4:0]  gap;
	// A long pause marks a new run, whose first byte may jump.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap <= 5'h1f;
		end else if (ee_valid && ee_ready) begin
			gap <= 5'h00;
		end else if (gap != 5'h1f) begin
			gap <= gap + 5'h01;
		end
	end
	always_ff @(posedge aclk) begin
		if (ee_valid && ee_ready) begin
			last_addr <= ee_wr.addr;
		end
	end
	a_ee_hold: assert property (
		ee_valid && !ee_ready |=> ee_valid && $stable(ee_wr))
		else $error("EEPROM byte changed while stalled");
	a_ptr_step: assert property (
		ee_valid && ee_ready && gap < 5'h10 |->
		ee_wr.addr == last_addr + 16'h0001)
		else $error("EEPROM pointer did not step by one");
	a_map_hold: assert property (
		map_req && !map_ack |=> map_req && $stable(map_addr))
		else $error("map request dropped or moved");
	a_ack_to_ee: assert property (
		map_ack |=> ee_valid && !map_req && ee_wr.data == $past(map_rdata))
		else $error("map byte not passed to EEPROM");
	a_one_side: assert property (
		!(map_req && ee_valid))
		else $error("map read and EEPROM write together");
	a_read_lat: assert property (
		arvalid && arready |=> rvalid)
		else $error("read answer late");
	a_r_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	a_b_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	c_ee: cover property (ee_valid && ee_ready);
	c_stall: cover property (ee_valid && !ee_ready);
	c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
endmodule
bind ess_sequencer ess_sequencer_chk u_chk (.aclk, .aresetn, .arvalid,
	.arready, .rvalid, .rready, .rdata, .bvalid, .bready, .bresp, .map_req,
	.map_addr, .map_ack, .map_rdata, .ee_valid, .ee_ready, .ee_wr);
`default_nettype wire

// >>> ess_far_model.sv
// Behavioural register map and EEPROM beyond the sequencer.
`timescale 1ns/1ns
`default_nettype none
module ess_far_model
	import ess_pkg::*;
(
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Register map read port.
	input  wire logic        map_req,
	input  wire logic [15:0] map_addr,
	output logic             map_ack,
	output logic [7:0]       map_rdata,
	// EEPROM byte write port.
	input  wire logic        ee_valid,
	output logic             ee_ready,
	input  wire ess_ee_wr_t  ee_wr
);
	logic [7:0] mem [0:511];
	logic [2:0] tick;
	int         nwr;
	// The tick mixes prompt answers with stalls of up to two cycles.
	wire logic  take = aresetn && map_req && !map_ack && tick[0];
	always_ff @(posedge aclk) begin
		tick <= aresetn ? tick + 3'h1 : 3'h0;
		ee_ready <= aresetn && tick[1];
	end
	// Between answers the byte toggles, so a stale value never matches.
	always_ff @(posedge aclk) begin
		map_ack <= take;
		map_rdata <= take ? map_addr[7:0] ^ map_addr[15:8] ^ 8'h5a :
			aresetn ? ~map_rdata : 8'h00;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nwr <= 0;
		end else if (ee_valid && ee_ready) begin
			mem[ee_wr.addr[8:0]] <= ee_wr.data;
			nwr <= nwr + 1;
		end
	end
endmodule
`default_nettype wire

// >>> tb_top.sv
// Testbench for the EEPROM store sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import ess_pkg::*;
;
	logic        aclk = 0, aresetn = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic [15:0] awaddr = 16'h0, araddr = 16'h0;
	logic [31:0] wdata = 32'h0, d;
	logic [3:0]  wstrb = 4'hf;
	logic [2:0]  prot = 3'h0;
	logic [1:0]  r;
	wire logic   awready, wready, bvalid, arready, rvalid;
	wire logic   map_req, map_ack, ee_valid, ee_ready;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [15:0] map_addr;
	wire logic [7:0]  map_rdata;
	wire ess_ee_wr_t  ee_wr;
	int          num_errors = 0, checks = 0, cycles = 0;
	ess_sequencer u_ess_sequencer (.aclk, .aresetn, .awvalid, .awready,
		.awaddr, .awprot(prot), .wvalid, .wready, .wdata, .wstrb, .bvalid,
		.bready, .bresp, .arvalid, .arready, .araddr, .arprot(prot),
		.rvalid, .rready, .rdata, .rresp, .map_req, .map_addr, .map_ack,
		.map_rdata, .ee_valid, .ee_ready, .ee_wr);
	ess_far_model u_ess_far_model (.aclk, .aresetn, .map_req, .map_addr,
		.map_ack, .map_rdata, .ee_valid, .ee_ready, .ee_wr);
	always #20 aclk = ~aclk;
	task automatic finish_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [11:0] i, input logic [31:0] v);
		bit a, w;
		a = 0;
		w = 0;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= {2'h0, i, 2'h0};
		wdata <= v;
		do begin
			@(posedge aclk);
			if (awready && !a) begin
				a = 1;
				awvalid <= 1'b0;
			end
			if (wready && !w) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end while (!(a && w));
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] i);
		arvalid <= 1'b1;
		araddr <= {2'h0, i, 2'h0};
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	// One full run from base b; entry 0 may carry non-default values.
	task automatic run_check(input logic [15:0] b, input int n,
		input logic [7:0] i0, input logic [15:0] s0);
		logic [7:0]  ins;
		logic [15:0] st;
		int          q;
		wr(IDX_BASE, {16'h0, b});
		wr(IDX_CTRL, 32'h1);
		// A second start lands while busy and must not restart the run.
		wr(IDX_CTRL, 32'h1);
		rd(IDX_STATUS);
		chk(d, 32'h1);
		do rd(IDX_STATUS); while (d[1] !== 1'b1);
		chk(d, 32'h2);
		rd(IDX_POINTER);
		q = b + PRIOR_HEADER_BYTES + PRIOR_DATA_ADVANCE;
		for (int e = 0; e < SEQ_ENTRIES; e++) begin
			ins = (e == 0) ? i0 : INSTR_RESET[e];
			st  = (e == 0) ? s0 : START_RESET[e];
			chk(u_ess_far_model.mem[q], ins);
			chk(u_ess_far_model.mem[q+1], st[15:8]);
			chk(u_ess_far_model.mem[q+2], st[7:0]);
			for (int k = 0; k <= ins; k++) begin
				chk(u_ess_far_model.mem[q+3+k], pat(16'(st + k)));
			end
			q += 4 + ins;
		end
		chk(d, q);
		chk(u_ess_far_model.nwr, n);
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < SEQ_ENTRIES; i++) begin
			rd(IDX_INSTR[i]);
			chk(d, {24'h0, INSTR_RESET[i]});
			rd(IDX_START[i]);
			chk(d, {16'h0, START_RESET[i]});
		end
		rd(12'h123);
		chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
		wr(12'h124, 32'h1);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		run_check(16'h0100, 107, INSTR_RESET[0], START_RESET[0]);
		// Only the low byte lane of the start register may change.
		wstrb <= 4'h1;
		wr(IDX_START[0], 32'h0000_beef);
		wstrb <= 4'hf;
		rd(IDX_START[0]);
		chk(d, 32'h0000_04ef);
		// A one-byte entry, continuing right after the first run.
		wr(IDX_INSTR[0], 32'h0);
		run_check(16'h016b, 200, 8'h00, 16'h04ef);
		finish_test();
	end
endmodule
`default_nettype wire
